// ---- src/i2c_status_flags_regs.vh ----
// Purpose: Register map, field positions and reset values for the serial status-flag block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Definitions only
`ifndef I2C_STATUS_FLAGS_REGS_VH
`define I2C_STATUS_FLAGS_REGS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_STATUS 8'h00
`define ADDR_CTRL 8'h04
`define ADDR_OWN_ADDR 8'h08
`define ADDR_TX_HOLD 8'h0c
`define ADDR_RX_HOLD 8'h10
`define ADDR_IRQ_STATUS 8'h14
`define ADDR_IRQ_MASK 8'h18
`define ADDR_PIN_FUNC 8'hf8

// ----------------------------------------
// Status register bits
// ----------------------------------------
`define ST_AAS 1
`define ST_AL 2
`define ST_STOP 3
`define ST_NACK 4
`define ST_RX_BUFFER_FULL 5
`define ST_TX_COMPLETE_FLAG 6
`define ST_TX_BUFFER_EMPTY 7
`define STATUS_RESET 8'h00

// ----------------------------------------
// Control register bits
// ----------------------------------------
`define CT_ACK_CHECK_ENABLE 0
`define CT_TRS 1
`define CT_MST 2
`define CT_TIE 3
`define CT_TEIE 4
`define CT_RIE 5
`define CT_STIE 6
`define CT_NAKIE 7
`define CTRL_RESET 8'h00

// ----------------------------------------
// Pin function select bits
// ----------------------------------------
`define PF_SEL_PIN 3
`define PF_TWO_WIRE 7
`define PF_WRITE_MASK 8'h88
`define PF_RESET 8'h00

// ----------------------------------------
// Frame counts and widths
// ----------------------------------------
`define LAST_DATA_BIT 4'h7
`define ACK_BIT 4'h8
`define OWN_ADDR_RESET 7'h00
`define BYTE_ZERO 8'h00
`define WORD_ZERO 32'h0000_0000

`endif

// ---- src/i2c_status_flags.v ----
// Purpose: Status flags of a two-wire / clock synchronous serial unit with an APB register port
// Assumes: SCL and SDA arrive asynchronously and are synchronised by two flip-flops each
// Notes: Transfer clock generation and full transfer sequencing live elsewhere; SCL is always an input here
`timescale 1ns/100ps
`include "i2c_status_flags_regs.vh"

module i2c_status_flags (
  // Clock and reset
  input wire CLK_IN,
  input wire RESET_N_IN,
  // APB slave
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [7:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output reg PREADY_OUT,
  output reg PSLVERR_OUT,
  // Serial pins
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE_OUT,
  // Select signal pin routing
  output reg SELECT_FIRST_PIN_EN_OUT,
  output reg SELECT_ALT_PIN_EN_OUT,
  // Interrupts
  output reg INT_REQ_OUT,
  output reg IRQ_OUT
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Event flag write: a zero clears, a one leaves it alone
  function clear_on_zero;
    input old_bit;
    input wr_bit;
    begin
      clear_on_zero = old_bit & wr_bit;
    end
  endfunction

  // Address decode shared by read and write paths
  function is_mapped;
    input [7:0] addr;
    begin
      is_mapped = (addr == `ADDR_STATUS) || (addr == `ADDR_CTRL) || (addr == `ADDR_OWN_ADDR) ||
                  (addr == `ADDR_TX_HOLD) || (addr == `ADDR_RX_HOLD) || (addr == `ADDR_IRQ_STATUS) ||
                  (addr == `ADDR_IRQ_MASK) || (addr == `ADDR_PIN_FUNC);
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [7:0] status_reg;
  reg [7:0] ctrl_reg;
  reg [6:0] own_addr_reg;
  reg [7:0] tx_hold_reg;
  reg [7:0] rx_hold_reg;
  reg [7:0] irq_status_reg;
  reg [7:0] irq_mask_reg;
  reg [7:0] pin_func_reg;
  reg [7:0] status_prev_reg;
  reg [7:0] shift_in_reg;
  reg [7:0] shift_out_reg;
  reg tx_loaded_reg;
  reg [3:0] bit_cnt_reg;
  reg first_frame_reg;
  reg frame_seen_reg;
  reg addressed_reg;
  reg lost_reg;
  reg scl_meta_reg;
  reg scl_sync_reg;
  reg scl_prev_reg;
  reg sda_meta_reg;
  reg sda_sync_reg;
  reg sda_prev_reg;
  reg sda_drive_low_reg;

  // ----------------------------------------
  // Decoded bus and pin events
  // ----------------------------------------
  wire two_wire = pin_func_reg[`PF_TWO_WIRE];
  wire transmit = ctrl_reg[`CT_TRS];
  wire master = ctrl_reg[`CT_MST];
  wire setup_phase = PSEL_IN & ~PENABLE_IN;
  wire access_done = PSEL_IN & PENABLE_IN & PREADY_OUT;
  wire wr_done = access_done & PWRITE_IN & ~PSLVERR_OUT;
  wire rd_done = access_done & ~PWRITE_IN & ~PSLVERR_OUT;
  wire [7:0] wbyte = PWDATA_IN[7:0];
  wire scl_rise = scl_sync_reg & ~scl_prev_reg;
  wire scl_fall = ~scl_sync_reg & scl_prev_reg;
  // Start and stop only mean something on the two-wire bus
  wire start_det = two_wire & scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  wire stop_det = two_wire & scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
  wire byte_end = scl_rise & (bit_cnt_reg == `LAST_DATA_BIT);
  wire ack_clock = scl_rise & two_wire & (bit_cnt_reg == `ACK_BIT);
  wire [7:0] rx_byte = {shift_in_reg[6:0], sda_sync_reg};
  // Holding to shift move: idle shift register, SCL low, never in the cycle of a new holding write
  wire tx_move = transmit && !tx_loaded_reg && !status_reg[`ST_TX_BUFFER_EMPTY] && !scl_sync_reg && bit_cnt_reg == 4'h0 &&
                 !(wr_done && PADDR_IN == `ADDR_TX_HOLD);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------

  // Three flops per pin; the second stage is looked at, the third only as its previous value for edges
  always @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= SCL_IN;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= SDA_IN;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  // ----------------------------------------
  // APB response
  // ----------------------------------------

  // Zero-wait answer: ready rises for the access phase that follows every setup
  always @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= `WORD_ZERO;
    end else begin
      PREADY_OUT <= setup_phase;
      PSLVERR_OUT <= setup_phase & ~is_mapped(PADDR_IN);
      if (setup_phase && !PWRITE_IN) begin
        case (PADDR_IN)
          `ADDR_STATUS: PRDATA_OUT <= {24'h00_0000, status_reg};
          `ADDR_CTRL: PRDATA_OUT <= {24'h00_0000, ctrl_reg};
          `ADDR_OWN_ADDR: PRDATA_OUT <= {25'h000_0000, own_addr_reg};
          `ADDR_TX_HOLD: PRDATA_OUT <= {24'h00_0000, tx_hold_reg};
          `ADDR_RX_HOLD: PRDATA_OUT <= {24'h00_0000, rx_hold_reg};
          `ADDR_IRQ_STATUS: PRDATA_OUT <= {24'h00_0000, irq_status_reg};
          `ADDR_IRQ_MASK: PRDATA_OUT <= {24'h00_0000, irq_mask_reg};
          `ADDR_PIN_FUNC: PRDATA_OUT <= {24'h00_0000, pin_func_reg};
          default: PRDATA_OUT <= `WORD_ZERO;
        endcase
      end else if (!PSEL_IN) begin
        PRDATA_OUT <= `WORD_ZERO;
      end
    end
  end

  // ----------------------------------------
  // Plain configuration registers
  // ----------------------------------------

  // Reserved pin-function bits are forced to zero on write
  always @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      own_addr_reg <= `OWN_ADDR_RESET;
      irq_mask_reg <= `BYTE_ZERO;
      pin_func_reg <= `PF_RESET;
    end else if (wr_done) begin
      if (PADDR_IN == `ADDR_OWN_ADDR)
        own_addr_reg <= wbyte[6:0];
      if (PADDR_IN == `ADDR_IRQ_MASK)
        irq_mask_reg <= wbyte;
      if (PADDR_IN == `ADDR_PIN_FUNC)
        pin_func_reg <= wbyte & `PF_WRITE_MASK;
    end
  end

  // ----------------------------------------
  // Flags and shift engine
  // ----------------------------------------

  // Software clears come first so that hardware sets in the same cycle win
  always @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      status_reg <= `STATUS_RESET;
      ctrl_reg <= `CTRL_RESET;
      tx_hold_reg <= `BYTE_ZERO;
      rx_hold_reg <= `BYTE_ZERO;
      shift_in_reg <= `BYTE_ZERO;
      shift_out_reg <= `BYTE_ZERO;
      tx_loaded_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      first_frame_reg <= 1'b0;
      frame_seen_reg <= 1'b0;
      addressed_reg <= 1'b0;
      lost_reg <= 1'b0;
    end else begin
      // Register writes and reads with side effects
      if (wr_done && PADDR_IN == `ADDR_STATUS) begin
        status_reg[`ST_AAS] <= clear_on_zero(status_reg[`ST_AAS], wbyte[`ST_AAS]);
        status_reg[`ST_AL] <= clear_on_zero(status_reg[`ST_AL], wbyte[`ST_AL]);
        status_reg[`ST_STOP] <= clear_on_zero(status_reg[`ST_STOP], wbyte[`ST_STOP]);
        status_reg[`ST_NACK] <= clear_on_zero(status_reg[`ST_NACK], wbyte[`ST_NACK]);
      end
      if (wr_done && PADDR_IN == `ADDR_CTRL) begin
        ctrl_reg <= wbyte;
        if (wbyte[`CT_TRS] && !ctrl_reg[`CT_TRS])
          status_reg[`ST_TX_BUFFER_EMPTY] <= 1'b1;
      end
      if (wr_done && PADDR_IN == `ADDR_TX_HOLD) begin
        tx_hold_reg <= wbyte;
        status_reg[`ST_TX_BUFFER_EMPTY] <= 1'b0;
        status_reg[`ST_TX_COMPLETE_FLAG] <= 1'b0;
      end
      if (rd_done && PADDR_IN == `ADDR_RX_HOLD)
        status_reg[`ST_RX_BUFFER_FULL] <= 1'b0;

      // Holding register moves to an idle shift register at a byte boundary
      if (tx_move) begin
        shift_out_reg <= tx_hold_reg;
        tx_loaded_reg <= 1'b1;
        status_reg[`ST_TX_BUFFER_EMPTY] <= 1'b1;
      end

      // Start condition re-arms the frame counter
      if (start_det) begin
        bit_cnt_reg <= 4'h0;
        first_frame_reg <= 1'b1;
        addressed_reg <= 1'b0;
        lost_reg <= 1'b0;
        if (master && transmit)
          status_reg[`ST_TX_BUFFER_EMPTY] <= 1'b1;
        // Our own SDA was released, so somebody else made this start
        if (master && !sda_drive_low_reg)
          status_reg[`ST_AL] <= 1'b1;
      end else if (stop_det) begin
        bit_cnt_reg <= 4'h0;
        frame_seen_reg <= 1'b0;
        if (frame_seen_reg)
          status_reg[`ST_STOP] <= 1'b1;
      end else if (scl_rise) begin
        if (bit_cnt_reg <= `LAST_DATA_BIT) begin
          shift_in_reg <= rx_byte;
          shift_out_reg <= {shift_out_reg[6:0], 1'b0};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (two_wire && master && transmit && tx_loaded_reg && !lost_reg &&
              (shift_out_reg[7] != sda_sync_reg)) begin
            status_reg[`ST_AL] <= 1'b1;
            lost_reg <= 1'b1;
          end
        end
        if (ack_clock) begin
          bit_cnt_reg <= 4'h0;
          first_frame_reg <= 1'b0;
          frame_seen_reg <= 1'b1;
          if (transmit) begin
            tx_loaded_reg <= 1'b0;
            if (sda_sync_reg && ctrl_reg[`CT_ACK_CHECK_ENABLE])
              status_reg[`ST_NACK] <= 1'b1;
            if (status_reg[`ST_TX_BUFFER_EMPTY])
              status_reg[`ST_TX_COMPLETE_FLAG] <= 1'b1;
          end else if (first_frame_reg && addressed_reg && !master && rx_hold_reg[0]) begin
            // Read request from the master turns this slave round
            ctrl_reg[`CT_TRS] <= 1'b1;
            status_reg[`ST_TX_BUFFER_EMPTY] <= 1'b1;
          end
        end
        if (byte_end) begin
          if (!two_wire) begin
            bit_cnt_reg <= 4'h0;
            if (transmit) begin
              tx_loaded_reg <= 1'b0;
              status_reg[`ST_TX_COMPLETE_FLAG] <= 1'b1;
            end
          end
          if (!transmit) begin
            if (!two_wire && status_reg[`ST_RX_BUFFER_FULL] && !(rd_done && PADDR_IN == `ADDR_RX_HOLD)) begin
              status_reg[`ST_AL] <= 1'b1;
            end else begin
              rx_hold_reg <= rx_byte;
              status_reg[`ST_RX_BUFFER_FULL] <= 1'b1;
            end
            if (two_wire && first_frame_reg && !master && rx_byte[7:1] == own_addr_reg) begin
              status_reg[`ST_AAS] <= 1'b1;
              addressed_reg <= 1'b1;
            end
          end
        end
      end
    end
  end

  // ----------------------------------------
  // SDA drive
  // ----------------------------------------

  // Data only changes while SCL is low so no false start or stop is made
  always @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      sda_drive_low_reg <= 1'b0;
      SDA_OUT <= 1'b1;
      SDA_OE_OUT <= 1'b0;
    end else if (tx_move) begin
      // First bit must stand before the first clock rise, so it goes out with the load
      sda_drive_low_reg <= two_wire && !lost_reg && !tx_hold_reg[7];
      SDA_OUT <= !two_wire && tx_hold_reg[7];
      SDA_OE_OUT <= !two_wire || (!lost_reg && !tx_hold_reg[7]);
    end else if (scl_fall) begin
      if (two_wire) begin
        // Open drain: pull low for a zero data bit or for our acknowledge
        sda_drive_low_reg <= (transmit && tx_loaded_reg && !lost_reg && bit_cnt_reg <= `LAST_DATA_BIT &&
                              !shift_out_reg[7]) ||
                             (!transmit && bit_cnt_reg == `ACK_BIT && (master || addressed_reg));
        SDA_OUT <= 1'b0;
        SDA_OE_OUT <= (transmit && tx_loaded_reg && !lost_reg && bit_cnt_reg <= `LAST_DATA_BIT &&
                       !shift_out_reg[7]) ||
                      (!transmit && bit_cnt_reg == `ACK_BIT && (master || addressed_reg));
      end else begin
        // Push-pull data line in the synchronous format
        sda_drive_low_reg <= 1'b0;
        SDA_OUT <= shift_out_reg[7];
        SDA_OE_OUT <= transmit && tx_loaded_reg;
      end
    end else if (!two_wire && !transmit) begin
      SDA_OE_OUT <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pin routing and interrupts
  // ----------------------------------------

  // Select pin only carries the signal while the synchronous unit owns the hardware
  always @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      SELECT_FIRST_PIN_EN_OUT <= 1'b0;
      SELECT_ALT_PIN_EN_OUT <= 1'b0;
    end else begin
      SELECT_FIRST_PIN_EN_OUT <= !two_wire && !pin_func_reg[`PF_SEL_PIN];
      SELECT_ALT_PIN_EN_OUT <= !two_wire && pin_func_reg[`PF_SEL_PIN];
    end
  end

  // Sticky events follow flag rising edges, one cycle behind the flag itself
  always @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      status_prev_reg <= `STATUS_RESET;
      irq_status_reg <= `BYTE_ZERO;
      INT_REQ_OUT <= 1'b0;
      IRQ_OUT <= 1'b0;
    end else begin
      status_prev_reg <= status_reg;
      if (wr_done && PADDR_IN == `ADDR_IRQ_STATUS)
        irq_status_reg <= (irq_status_reg & ~wbyte) | (status_reg & ~status_prev_reg);
      else
        irq_status_reg <= irq_status_reg | (status_reg & ~status_prev_reg);
      IRQ_OUT <= |(irq_status_reg & irq_mask_reg);
      INT_REQ_OUT <= (ctrl_reg[`CT_TIE] && status_reg[`ST_TX_BUFFER_EMPTY]) ||
                     (ctrl_reg[`CT_TEIE] && status_reg[`ST_TX_COMPLETE_FLAG]) ||
                     (ctrl_reg[`CT_RIE] && status_reg[`ST_RX_BUFFER_FULL]) ||
                     (ctrl_reg[`CT_STIE] && two_wire && status_reg[`ST_STOP]) ||
                     (ctrl_reg[`CT_NAKIE] && (status_reg[`ST_AL] || status_reg[`ST_NACK]));
    end
  end

endmodule // i2c_status_flags

// ---- sim/i2c_status_flags_checker.sv ----
// Purpose: Port-level checks of the serial status-flag block
// Assumes: Zero-wait APB slave, registered pin routing outputs
// Notes: Bound to the block top, sees its ports only
`timescale 1ns/100ps
`include "i2c_status_flags_regs.vh"

module i2c_status_flags_checker (
  // Clock and reset
  input wire CLK_IN,
  input wire RESET_N_IN,
  // APB
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [7:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  input wire [31:0] PRDATA_OUT,
  input wire PREADY_OUT,
  input wire PSLVERR_OUT,
  // Pin routing
  input wire SELECT_FIRST_PIN_EN_OUT,
  input wire SELECT_ALT_PIN_EN_OUT
);
  // ----------------------------------------
  // Bus phases
  // ----------------------------------------
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // Word offsets up to the mask word, plus the pin function word
  wire mapped = (PADDR_IN <= `ADDR_IRQ_MASK && PADDR_IN[1:0] == 2'b00) || PADDR_IN == `ADDR_PIN_FUNC;
  sequence s_setup;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence s_pin_wr;
    PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == `ADDR_PIN_FUNC;
  endsequence
  // Routing that the written pin-function byte asks for
  wire cfg_first = !PWDATA_IN[`PF_TWO_WIRE] && !PWDATA_IN[`PF_SEL_PIN];
  wire cfg_alt = !PWDATA_IN[`PF_TWO_WIRE] && PWDATA_IN[`PF_SEL_PIN];
  wire pins_off = !SELECT_FIRST_PIN_EN_OUT && !SELECT_ALT_PIN_EN_OUT;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ready_after_setup: assert property (s_setup |=> PREADY_OUT)
    else $error("No ready after setup");
  a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("Ready held too long");
  a_err_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("Error without ready");
  a_unmapped_err: assert property (s_setup ##0 !mapped |=> PSLVERR_OUT && PREADY_OUT)
    else $error("Unmapped access not refused");
  a_mapped_ok: assert property (s_setup ##0 mapped |=> !PSLVERR_OUT)
    else $error("Mapped access refused");
  a_rdata_byte_only: assert property (PREADY_OUT |-> PRDATA_OUT[31:8] == 24'h00_0000)
    else $error("Upper read data not zero");
  a_pins_exclusive: assert property (!(SELECT_FIRST_PIN_EN_OUT && SELECT_ALT_PIN_EN_OUT))
    else $error("Both select pins enabled");
  a_first_pin_on: assert property (s_pin_wr ##0 cfg_first |-> ##[1:2] SELECT_FIRST_PIN_EN_OUT)
    else $error("First select pin not routed");
  a_alt_pin_on: assert property (s_pin_wr ##0 cfg_alt |-> ##[1:2] SELECT_ALT_PIN_EN_OUT)
    else $error("Alternate select pin not routed");
  a_two_wire_pins: assert property (s_pin_wr ##0 PWDATA_IN[`PF_TWO_WIRE] |-> ##[1:2] pins_off)
    else $error("Select pins active in two-wire mode");
endmodule // i2c_status_flags_checker

bind i2c_status_flags i2c_status_flags_checker chk_u (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .SELECT_FIRST_PIN_EN_OUT(SELECT_FIRST_PIN_EN_OUT), .SELECT_ALT_PIN_EN_OUT(SELECT_ALT_PIN_EN_OUT));

// ---- sim/i2c_bus_partner.sv ----
// Purpose: Far-side bus party driving the serial clock and data line
// Assumes: Open-drain data line with pull-up, 125 ns bit period
// Notes: Clock stands still between frames
`timescale 1ns/100ps

module i2c_bus_partner (
  // Line levels seen by the block
  output logic scl_out,
  output wire sda_line_out,
  // Block side of the data pin
  input wire logic dut_oe_in,
  input wire logic dut_data_in
);
  logic sda_drv;
  // Either party may pull low; a released line reads high
  assign sda_line_out = dut_oe_in ? (dut_data_in & sda_drv) : sda_drv;
  // Idle bus
  initial begin
    scl_out = 1'b1;
    sda_drv = 1'b1;
  end
  // Data changes only while the clock is low
  task automatic one_bit(input logic v);
    sda_drv = v;
    #31.25 scl_out = 1'b1;
    #62.5 scl_out = 1'b0;
    #31.25;
  endtask
  // Start: data falls while clock high, clock then parks low
  task automatic bus_start();
    sda_drv = 1'b0;
    #62.5 scl_out = 1'b0;
    #62.5;
  endtask
  // Stop: data rises while clock high
  task automatic bus_stop();
    sda_drv = 1'b0;
    #62.5 scl_out = 1'b1;
    #62.5 sda_drv = 1'b1;
    #62.5;
  endtask
  // Byte then a released acknowledge slot
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) one_bit(b[i]);
    one_bit(1'b1);
  endtask
  // Synchronous format: eight clocks, no acknowledge, clock left low
  task automatic sync_byte(input logic [7:0] b);
    scl_out = 1'b0;
    #31.25;
    for (int i = 7; i >= 0; i--) one_bit(b[i]);
    sda_drv = 1'b1;
  endtask
endmodule // i2c_bus_partner

// ---- sim/i2c_status_flags_test.sv ----
// Purpose: Self-checking bench for the serial status-flag block
// Assumes: Zero-wait APB, flags readable a few cycles after bus events
// Notes: Read results are checked against a queue of notes
`timescale 1ns/100ps

module i2c_status_flags_test;
  logic clk = 1'b0;
  logic rst_n, psel, penable, pwrite, sda_out, sda_oe, first_en, alt_en, int_req, irq, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [64:0] notes [$];
  logic [6:0] own;
  logic [7:0] d;
  logic [7:0] rxd;
  logic [7:0] pf [5] = '{8'h77, 8'h08, 8'hff, 8'h00, 8'h00};
  wire scl, sda;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;

  // ----------------------------------------
  // Block, bus partner, clock
  // ----------------------------------------
  i2c_status_flags dut_u (.CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe),
    .SELECT_FIRST_PIN_EN_OUT(first_en), .SELECT_ALT_PIN_EN_OUT(alt_en), .INT_REQ_OUT(int_req), .IRQ_OUT(irq));
  i2c_bus_partner p_u (.scl_out(scl), .sda_line_out(sda), .dut_oe_in(sda_oe), .dut_data_in(sda_out));
  always #5 clk = ~clk;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  // Note is {refused, mask, expected}
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic err);
    notes.push_back({err, m, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic chk_rd(input logic [64:0] n);
    n_compared++;
    if ((prdata & n[63:32]) !== (n[31:0] & n[63:32]) || pslverr !== n[64]) begin
      bad_count++;
      $display("CHECK FAILED read %h expected %h/%b seen %h/%b", paddr, n[31:0], n[64], prdata, pslverr);
    end
  endtask
  task automatic chk(input string name, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, e, g);
    end
  endtask
  task automatic chk_byte(input string name, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask
  // Line level taken at every serial clock rise, as a far-side receiver would
  always @(posedge scl) begin
    rxd <= {rxd[6:0], sda};
  end

  // Oldest note is taken whenever a read completes
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk_rd(notes.pop_front());
  end
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    void'($urandom(34));
    pf[4] = 8'($urandom);
    own = 7'($urandom);
    d = 8'($urandom);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'hf8, 32'h0000_00ff, 32'h0000_0000, 1'b0);
    rd(8'h00, 32'h0000_00ff, 32'h0000_0000, 1'b0);
    rd(8'h40, 32'hffff_ffff, 32'h0000_0000, 1'b1);
    wr(8'h40, 32'h0000_00ff);
    foreach (pf[i]) begin
      wr(8'hf8, {24'h00_0000, pf[i]});
      rd(8'hf8, 32'h0000_00ff, {24'h00_0000, pf[i] & 8'h88}, 1'b0);
      repeat (2) @(posedge clk);
      chk("first pin", !pf[i][7] && !pf[i][3], first_en);
      chk("alt pin", !pf[i][7] && pf[i][3], alt_en);
    end
    // Transmit select raises empty; interrupt masked, unmasked, cleared
    wr(8'h04, 32'h0000_0008);
    wr(8'h04, 32'h0000_000a);
    rd(8'h00, 32'h0000_00c0, 32'h0000_0080, 1'b0);
    chk("tx empty request", 1'b1, int_req);
    chk("irq masked", 1'b0, irq);
    wr(8'h18, 32'h0000_0080);
    repeat (2) @(posedge clk);
    chk("irq", 1'b1, irq);
    wr(8'h14, 32'h0000_0080);
    repeat (2) @(posedge clk);
    chk("irq cleared", 1'b0, irq);
    wr(8'h0c, {24'h00_0000, d});
    rd(8'h00, 32'h0000_00c0, 32'h0000_0000, 1'b0);
    chk("tx empty request", 1'b0, int_req);
    // Slave receive: foreign address first, then our own
    wr(8'h04, 32'h0000_0000);
    wr(8'hf8, 32'h0000_0080);
    wr(8'h08, {25'h000_0000, own});
    p_u.bus_start();
    p_u.send_byte({own ^ 7'h01, 1'b0});
    p_u.bus_stop();
    rd(8'h00, 32'h0000_000a, 32'h0000_0008, 1'b0);
    rd(8'h10, 32'h0000_0000, 32'h0000_0000, 1'b0);
    wr(8'h00, 32'h0000_0008);
    rd(8'h00, 32'h0000_0008, 32'h0000_0008, 1'b0);
    wr(8'h00, 32'h0000_0000);
    rd(8'h00, 32'h0000_0008, 32'h0000_0000, 1'b0);
    p_u.bus_start();
    p_u.send_byte({own, 1'b0});
    rd(8'h00, 32'h0000_0026, 32'h0000_0022, 1'b0);
    rd(8'h10, 32'h0000_00ff, {24'h00_0000, own, 1'b0}, 1'b0);
    rd(8'h00, 32'h0000_0020, 32'h0000_0000, 1'b0);
    p_u.send_byte(d);
    rd(8'h10, 32'h0000_00ff, {24'h00_0000, d}, 1'b0);
    p_u.bus_stop();
    rd(8'h00, 32'h0000_000a, 32'h0000_000a, 1'b0);
    wr(8'h00, 32'h0000_0000);
    rd(8'h00, 32'h0000_001e, 32'h0000_0000, 1'b0);
    // Slave transmit, released acknowledge, with and without checking
    wr(8'h04, 32'h0000_0011);
    wr(8'h04, 32'h0000_0013);
    p_u.bus_start();
    p_u.send_byte(8'hff);
    p_u.bus_stop();
    rd(8'h00, 32'h0000_00d0, 32'h0000_00d0, 1'b0);
    chk("tx end request", 1'b1, int_req);
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0002);
    p_u.bus_start();
    p_u.send_byte(8'hff);
    p_u.bus_stop();
    rd(8'h00, 32'h0000_0010, 32'h0000_0000, 1'b0);
    // Master transmit: a foreign start, then a released one bit seen pulled low
    wr(8'h04, 32'h0000_0006);
    p_u.bus_start();
    rd(8'h00, 32'h0000_0004, 32'h0000_0004, 1'b0);
    wr(8'h00, 32'h0000_0000);
    wr(8'h0c, 32'h0000_00ff);
    p_u.send_byte(8'h00);
    p_u.bus_stop();
    rd(8'h00, 32'h0000_0004, 32'h0000_0004, 1'b0);
    wr(8'h00, 32'h0000_0000);
    // Synchronous format: second byte while still full is an overrun
    wr(8'h04, 32'h0000_0000);
    wr(8'hf8, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000, 32'h0000_0000, 1'b0);
    p_u.sync_byte(d);
    rd(8'h00, 32'h0000_0024, 32'h0000_0020, 1'b0);
    p_u.sync_byte(~d);
    rd(8'h00, 32'h0000_0024, 32'h0000_0024, 1'b0);
    // Synchronous transmit: load empties the holding register, last bit ends the frame
    wr(8'h04, 32'h0000_0002);
    wr(8'h0c, {24'h00_0000, d});
    rd(8'h00, 32'h0000_00c0, 32'h0000_0080, 1'b0);
    p_u.sync_byte(8'hff);
    chk_byte("sync data out", d, rxd);
    rd(8'h00, 32'h0000_0040, 32'h0000_0040, 1'b0);
    repeat (5) @(posedge clk);
    wrap_up();
  end
endmodule // i2c_status_flags_test
